// [src/mfio_pkg.sv]
// shared constants for the multi-function i/o port block
`default_nettype none
package mfio_pkg;
  localparam int unsigned GROUP_W       = 8;
  localparam int unsigned NIBBLE_W      = 4;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned DEGLITCH_PS   = 8000000;
  localparam int unsigned DEGLITCH_CYC  = DEGLITCH_PS / CLK_PERIOD_PS;
  localparam int unsigned STRAP_CYC     = 1;
  localparam logic [4:0]  ADDR_FIXED    = 5'h16;
  localparam logic [7:0]  DIR_RST       = 8'h00;
  localparam logic [15:0] LED_RST       = 16'h0000;
  localparam logic        PP_RST        = 1'b0;
endpackage
`default_nettype wire

// [src/mfio_pin_filter.sv]
// three-stage synchroniser with stability filter for one pin
`default_nettype none
module mfio_pin_filter #(
  parameter int unsigned STABLE_CYC = 1,
  parameter logic        RST_VAL    = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pin and filtered level
  input  wire logic pin_in,
  output logic      level_out
);
  localparam int unsigned CW = $clog2(STABLE_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(STABLE_CYC - 1);

  logic          s1_reg;
  logic          s2_reg;
  logic          s3_reg;
  logic [CW-1:0] cnt_reg;
  logic          level_reg;

  // synchroniser keeps sampling through reset so straps are caught
  always_ff @(posedge clk) begin
    s1_reg <= pin_in;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  // stability count on the agreed level
  always_ff @(posedge clk) begin
    if (rst || s2_reg != s3_reg || s3_reg == level_reg || cnt_reg == LAST) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level_reg <= (s2_reg == s3_reg) ? s3_reg : RST_VAL;
    end else if (s2_reg == s3_reg && s3_reg != level_reg && cnt_reg == LAST) begin
      level_reg <= s3_reg;
    end
  end

  assign level_out = level_reg;
endmodule // mfio_pin_filter
`default_nettype wire

// [src/mfio_port_pins.sv]
// sixteen-port multi-function i/o pin logic with straps and interrupt
`default_nettype none
//Function
//- second group: general-purpose, always push-pull
//- first group open-drain, push-pull by setting
//- each port switchable into led mode
//- power-up levels chosen from strap inputs
//- straps tied by board, set address, pattern
//- interrupt pulls low open-drain, else released
//- hard reset pin low resets device
//- direction bits: one input, zero output, reset output
//- strap pattern: each nibble high or low from its strap
//- deglitched input change interrupts, group read clears
//- bus address fixed bits plus strap levels
module mfio_port_pins
  import mfio_pkg::*;
#(
  parameter int unsigned DEGLITCH_CYCLES = DEGLITCH_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // device pins
  input  wire logic [7:0]  first_group_port_pin_i,
  output logic      [7:0]  first_group_port_pin_o,
  output logic      [7:0]  first_group_port_pin_oe,
  input  wire logic [7:0]  second_group_port_pin_i,
  output logic      [7:0]  second_group_port_pin_o,
  output logic      [7:0]  second_group_port_pin_oe,
  input  wire logic        address_strap_low,
  input  wire logic        address_strap_high,
  input  wire logic        hard_reset_in_n,
  output logic             interrupt_out_n_o,
  output logic             interrupt_out_n_oe,
  // configuration from host
  input  wire logic        cfg_we,
  input  wire logic [7:0]  first_group_direction,
  input  wire logic [7:0]  second_group_direction,
  input  wire logic [15:0] led_mode_en,
  input  wire logic        first_group_push_pull,
  input  wire logic        out_we,
  input  wire logic [15:0] out_data,
  // input state reads and device address
  input  wire logic        first_group_input_rd,
  input  wire logic        second_group_input_rd,
  output logic      [7:0]  first_group_input_state,
  output logic      [7:0]  second_group_input_state,
  output logic      [6:0]  device_address
);
  logic [15:0] pin_f;
  logic        strap_l_f;
  logic        strap_h_f;
  logic        hw_rst_f;
  logic        dev_reset;
  logic        strap_l_reg;
  logic        strap_h_reg;
  logic [7:0]  dir0_reg;
  logic [7:0]  dir1_reg;
  logic [15:0] led_reg;
  logic        pp_reg;
  logic [7:0]  out0_reg;
  logic [7:0]  out1_reg;
  logic [15:0] prev_reg;
  logic [15:0] chg;
  logic        pend0_reg;
  logic        pend1_reg;
  logic        pend0_next;
  logic        pend1_next;
  logic [7:0]  pat_hi;

  // pin synchronisers with deglitch on the ports
  genvar gi;
  generate
    for (gi = 0; gi < 2 * GROUP_W; gi++) begin : g_port
      mfio_pin_filter #(.STABLE_CYC(DEGLITCH_CYCLES), .RST_VAL(1'b0)) u_port (
        .clk       (clk),
        .rst       (rst),
        .pin_in    (gi < GROUP_W ? first_group_port_pin_i[gi % GROUP_W]
                                 : second_group_port_pin_i[gi % GROUP_W]),
        .level_out (pin_f[gi])
      );
    end
  endgenerate

  mfio_pin_filter #(.STABLE_CYC(STRAP_CYC), .RST_VAL(1'b0)) u_strap_l (
    .clk       (clk),
    .rst       (rst),
    .pin_in    (address_strap_low),
    .level_out (strap_l_f)
  );
  mfio_pin_filter #(.STABLE_CYC(STRAP_CYC), .RST_VAL(1'b0)) u_strap_h (
    .clk       (clk),
    .rst       (rst),
    .pin_in    (address_strap_high),
    .level_out (strap_h_f)
  );
  mfio_pin_filter #(.STABLE_CYC(STRAP_CYC), .RST_VAL(1'b1)) u_hw_rst (
    .clk       (clk),
    .rst       (rst),
    .pin_in    (hard_reset_in_n),
    .level_out (hw_rst_f)
  );

  assign dev_reset = rst | ~hw_rst_f;

  // straps caught while in reset
  always_ff @(posedge clk) begin
    if (dev_reset) begin
      strap_l_reg <= strap_l_f;
      strap_h_reg <= strap_h_f;
    end
  end

  // nibble pattern from straps
  assign pat_hi = {{NIBBLE_W{strap_h_f}}, {NIBBLE_W{strap_l_f}}};

  // host configuration
  always_ff @(posedge clk) begin
    if (dev_reset) begin
      dir0_reg <= DIR_RST;
      dir1_reg <= DIR_RST;
      led_reg  <= LED_RST;
      pp_reg   <= PP_RST;
    end else if (cfg_we) begin
      dir0_reg <= first_group_direction;
      dir1_reg <= second_group_direction;
      led_reg  <= led_mode_en;
      pp_reg   <= first_group_push_pull;
    end
  end

  // output levels, strap pattern at reset
  always_ff @(posedge clk) begin
    if (dev_reset) begin
      out0_reg <= pat_hi;
      out1_reg <= pat_hi;
    end else if (out_we) begin
      out0_reg <= out_data[7:0];
      out1_reg <= out_data[15:8];
    end
  end

  // pin drivers
  always_ff @(posedge clk) begin
    if (dev_reset) begin
      first_group_port_pin_o   <= '0;
      first_group_port_pin_oe  <= '0;
      second_group_port_pin_o  <= '0;
      second_group_port_pin_oe <= '0;
    end else begin
      for (int i = 0; i < GROUP_W; i++) begin
        if (led_reg[i] || dir0_reg[i]) begin
          first_group_port_pin_o[i]  <= 1'b0;
          first_group_port_pin_oe[i] <= 1'b0;
        end else if (pp_reg) begin
          first_group_port_pin_o[i]  <= out0_reg[i];
          first_group_port_pin_oe[i] <= 1'b1;
        end else begin
          first_group_port_pin_o[i]  <= 1'b0;
          first_group_port_pin_oe[i] <= ~out0_reg[i];
        end
        second_group_port_pin_o[i]  <= out1_reg[i];
        second_group_port_pin_oe[i] <= ~(led_reg[GROUP_W + i] | dir1_reg[i]);
      end
    end
  end

  // change detect on input ports
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= pin_f;
    end
  end
  assign chg = (pin_f ^ prev_reg) & {dir1_reg, dir0_reg} & ~led_reg;

  // sticky pending per group, set wins over read
  always_comb begin
    pend0_next = pend0_reg;
    pend1_next = pend1_reg;
    if (first_group_input_rd) begin
      pend0_next = 1'b0;
    end
    if (second_group_input_rd) begin
      pend1_next = 1'b0;
    end
    if (|chg[7:0]) begin
      pend0_next = 1'b1;
    end
    if (|chg[15:8]) begin
      pend1_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (dev_reset) begin
      pend0_reg          <= 1'b0;
      pend1_reg          <= 1'b0;
      interrupt_out_n_oe <= 1'b0;
    end else begin
      pend0_reg          <= pend0_next;
      pend1_reg          <= pend1_next;
      interrupt_out_n_oe <= pend0_next | pend1_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      interrupt_out_n_o        <= 1'b0;
      first_group_input_state  <= '0;
      second_group_input_state <= '0;
      device_address           <= '0;
    end else begin
      interrupt_out_n_o        <= 1'b0;
      first_group_input_state  <= pin_f[7:0];
      second_group_input_state <= pin_f[15:8];
      device_address           <= {ADDR_FIXED, strap_h_reg, strap_l_reg};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_in_reset;
    dev_reset;
  endsequence
  sequence s_running;
    !dev_reset [*2];
  endsequence

  a_second_push_pull: assert property (s_running |-> second_group_port_pin_oe ==
    ~($past(led_reg[15:8]) | $past(dir1_reg))) else $error("second group drive wrong");
  a_first_od_reset: assert property (s_in_reset |=> !pp_reg ##1
    (dev_reset || first_group_port_pin_o == 8'h00)) else $error("first group not open-drain");
  a_led_release: assert property ((!dev_reset && led_reg[0]) |=>
    (dev_reset || !first_group_port_pin_oe[0])) else $error("led port still driven");
  a_strap_pattern: assert property (s_in_reset |=>
    out1_reg == {{4{$past(strap_h_f)}}, {4{$past(strap_l_f)}}}) else $error("bad strap pattern");
  a_addr_straps: assert property (s_running |->
    device_address == {ADDR_FIXED, $past(strap_h_reg), $past(strap_l_reg)})
    else $error("address mismatch");
  a_int_open_drain: assert property (##1 (interrupt_out_n_o == 1'b0 &&
    interrupt_out_n_oe == (pend0_reg || pend1_reg)))
    else $error("interrupt pin driven high");
  a_int_set: assert property ((!dev_reset && |chg[7:0]) |=>
    (dev_reset || (pend0_reg && interrupt_out_n_oe))) else $error("change not flagged");
  a_int_clear: assert property ((!dev_reset && first_group_input_rd && chg[7:0] == 8'h00)
    |=> !pend0_reg) else $error("read did not clear");
  a_hw_reset: assert property (!hw_rst_f |=> dir0_reg == 8'h00 && dir1_reg == 8'h00
    && led_reg == 16'h0000 && !pp_reg) else $error("hard reset kept settings");
  a_dir_input: assert property ((s_running and dir1_reg[3]) |->
    !second_group_port_pin_oe[3] || !$past(dir1_reg[3])) else $error("input port driven");
endmodule // mfio_port_pins
`default_nettype wire

// [testbench/mfio_board.sv]
// board model: pull-ups, external drivers, reset pin pull-down
`default_nettype none
module mfio_board (
  // device outputs
  input  wire logic [7:0] p0_o,
  input  wire logic [7:0] p0_oe,
  input  wire logic [7:0] p1_o,
  input  wire logic [7:0] p1_oe,
  input  wire logic       int_o,
  input  wire logic       int_oe,
  // external drivers
  input  wire logic [7:0] ext0,
  input  wire logic [7:0] en0,
  input  wire logic [7:0] ext1,
  input  wire logic [7:0] en1,
  input  wire logic       hr_con,
  input  wire logic       hr_drv,
  // resolved wires
  output logic      [7:0] p0_lvl,
  output logic      [7:0] p1_lvl,
  output logic            int_n,
  output logic            hr_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // first group has pull-ups for open-drain use
  assign p0_lvl = (p0_oe & p0_o) | (~p0_oe & ((en0 & ext0) | ~en0));
  // undriven second group floats: show inverse of last value
  assign p1_lvl = (p1_oe & p1_o) | (~p1_oe & ((en1 & ext1) | (~en1 & ~p1_o)));
  assign int_n  = int_oe ? int_o : 1'b1;
  assign hr_n   = hr_con ? hr_drv : 1'b0;
endmodule // mfio_board
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the multi-function port pins
`default_nettype none
module tb import mfio_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, sl, sh, cfg_we, pp, out_we, rd0, rd1, hr_con, hr_drv;
  logic [7:0] dir0, dir1, ext0, ext1, en0, en1;
  logic [15:0] led, od;
  wire logic [7:0] p0_o, p0_oe, p1_o, p1_oe, p0_i, p1_i, st0, st1;
  wire logic io, ioe, hr_n, int_n;
  wire logic [6:0] addr;
  int mismatches, tests_run, cyc;

  mfio_port_pins #(.DEGLITCH_CYCLES(4)) uut (.clk(clk), .rst(rst),
    .first_group_port_pin_i(p0_i), .first_group_port_pin_o(p0_o),
    .first_group_port_pin_oe(p0_oe), .second_group_port_pin_i(p1_i),
    .second_group_port_pin_o(p1_o), .second_group_port_pin_oe(p1_oe),
    .address_strap_low(sl), .address_strap_high(sh), .hard_reset_in_n(hr_n),
    .interrupt_out_n_o(io), .interrupt_out_n_oe(ioe), .cfg_we(cfg_we),
    .first_group_direction(dir0), .second_group_direction(dir1),
    .led_mode_en(led), .first_group_push_pull(pp), .out_we(out_we),
    .out_data(od), .first_group_input_rd(rd0), .second_group_input_rd(rd1),
    .first_group_input_state(st0), .second_group_input_state(st1),
    .device_address(addr));

  mfio_board brd (.p0_o(p0_o), .p0_oe(p0_oe), .p1_o(p1_o), .p1_oe(p1_oe),
    .int_o(io), .int_oe(ioe), .ext0(ext0), .en0(en0), .ext1(ext1), .en1(en1),
    .hr_con(hr_con), .hr_drv(hr_drv), .p0_lvl(p0_i), .p1_lvl(p1_i),
    .int_n(int_n), .hr_n(hr_n));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish;
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic cfg(input logic [7:0] d0, input logic [7:0] d1,
                     input logic [15:0] l, input logic p);
    @(posedge clk);
    dir0 <= d0; dir1 <= d1; led <= l; pp <= p; cfg_we <= 1'b1;
    @(posedge clk);
    cfg_we <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic g);
    @(posedge clk);
    if (g) rd1 <= 1'b1;
    else rd0 <= 1'b1;
    @(posedge clk);
    rd0 <= 1'b0; rd1 <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic wait_int(input logic lvl);
    for (int i = 0; i < 60 && int_n !== lvl; i++) @(posedge clk);
    #1;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    logic [7:0] pat;
    rst = 1'b1; sl = 1'b0; sh = 1'b0; cfg_we = 1'b0; pp = 1'b0; out_we = 1'b0;
    rd0 = 1'b0; rd1 = 1'b0; hr_con = 1'b1; hr_drv = 1'b1; dir0 = 8'h00;
    dir1 = 8'h00; ext0 = 8'h00; ext1 = 8'h00; en0 = 8'h00; en1 = 8'h00;
    led = 16'h0000; od = 16'h0000; mismatches = 0; tests_run = 0; cyc = 0;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      rst <= 1'b1; sl <= k[0]; sh <= k[1];
      repeat (6) @(posedge clk);
      #1;
      chk({p0_oe, p1_oe}, 16'h0000);
      @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      pat = {{4{k[1]}}, {4{k[0]}}};
      chk({p1_oe, p1_o}, {8'hff, pat});
      chk({p0_oe, p0_o}, {~pat, 8'h00});
      chk({9'h0, addr}, {9'h0, ADDR_FIXED, k[1], k[0]});
      chk({15'h0, int_n}, 16'h0001);
    end
    @(posedge clk);
    od <= 16'h5aa5; out_we <= 1'b1;
    @(posedge clk);
    out_we <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({p1_oe, p1_o}, 16'hff5a);
    chk({p0_oe, p0_o}, 16'h5a00);
    cfg(8'h00, 8'h00, 16'h0000, 1'b1);
    chk({p0_oe, p0_o}, 16'hffa5);
    cfg(8'h00, 8'h00, 16'h8001, 1'b1);
    chk({p0_oe, p0_o}, 16'hfea4);
    chk({p1_oe, p1_o}, 16'h7f5a);
    @(posedge clk);
    en1 <= 8'h0f;
    cfg(8'h01, 8'h0f, 16'h0000, 1'b0);
    chk({p1_oe, p0_oe}, 16'hf05a);
    repeat (20) @(posedge clk);
    rd(1'b0);
    rd(1'b1);
    chk({15'h0, int_n}, 16'h0001);
    @(posedge clk);
    ext1 <= 8'h04;
    wait_int(1'b0);
    chk({15'h0, int_n}, 16'h0000);
    chk({8'h00, st1}, 16'h0054);
    rd(1'b0);
    chk({15'h0, int_n}, 16'h0000);
    rd(1'b1);
    chk({15'h0, int_n}, 16'h0001);
    @(posedge clk);
    en0 <= 8'h01;
    wait_int(1'b0);
    chk({15'h0, int_n}, 16'h0000);
    chk({8'h00, st0}, 16'h00a4);
    rd(1'b1);
    chk({15'h0, int_n}, 16'h0000);
    rd(1'b0);
    chk({15'h0, int_n}, 16'h0001);
    @(posedge clk);
    hr_drv <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk({p0_oe, p1_oe}, 16'h0000);
    @(posedge clk);
    hr_drv <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk({p1_oe, p1_o}, 16'hffff);
    chk({p0_oe, p0_o}, 16'h0000);
    @(posedge clk);
    hr_con <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk({p0_oe, p1_oe}, 16'h0000);
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
